/* File: inc/ssof_pkg.sv */
/*
 * Package for the servo status output flag block: bus offsets, field
 * positions, reset values, timing counts and the carrier structs.
 * Assumes a 10 MHz system clock and an AXI4-Lite register master.
 */
package ssof_pkg;
   // =========================================================
   // Clock and power-on windows
   // =========================================================
   localparam int CLK_HZ = 10_000_000;
   // Window figures in milliseconds
   localparam int PON_SINGLE_MIN_MS = 2500;
   localparam int PON_SINGLE_MAX_MS = 3500;
   localparam int PON_MULTI_MIN_MS = 3500;
   localparam int PON_MULTI_MAX_MS = 4000;
   // Target inside each window: midpoint, rounded to whole cycles
   localparam int PON_SINGLE_CYC =
      (PON_SINGLE_MIN_MS + PON_SINGLE_MAX_MS) / 2 * (CLK_HZ / 1000);
   localparam int PON_MULTI_CYC =
      (PON_MULTI_MIN_MS + PON_MULTI_MAX_MS) / 2 * (CLK_HZ / 1000);
   // =========================================================
   // Speed figures (r/min or mm/s, signed 16-bit)
   // =========================================================
   localparam int SPD_W = 16;
   localparam logic [15:0] SA_OFFSET = 16'h0014;      // 20 units
   localparam logic [15:0] SA_MIN_SET = 16'h0014;     // 20 units
   localparam logic [15:0] ZSP_HYST = 16'h0014;       // 20 units
   localparam logic [15:0] ZSP_LEVEL_RST = 16'h0032;  // 50 units
   // =========================================================
   // Register map (byte addresses)
   // =========================================================
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_INPOS = 8'h04;
   localparam logic [7:0] REG_ZSPD = 8'h08;
   localparam logic [7:0] REG_BRAKE = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   // CTRL fields
   localparam int CTRL_MULTI = 0;
   localparam int CTRL_BATLESS = 1;
   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] INPOS_RST = 32'h0000_0064;
   localparam logic [31:0] BRAKE_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control modes
   typedef enum logic [1:0] {
      SSOF_POS, SSOF_VEL, SSOF_TRQ
   } ssof_mode_e;

   // Internal drive state feeding the flags
   typedef struct packed {
      logic servo_on;
      logic ready_on_cmd;
      logic base_shutoff;
      logic alarm;
      logic conv_alarm;
      logic warning;
      logic bat_warning;
      logic stop_warning;
      logic gain1;
      logic gain2;
      logic abs_lost;
      logic closed_loop;
      logic at_speed_limit;
      logic at_torque_limit;
      ssof_mode_e mode;
      logic [31:0] droop;
      logic [15:0] speed;
      logic [15:0] set_speed;
   } ssof_drive_s;

   // Output flags
   typedef struct packed {
      logic malfunction;
      logic in_position;
      logic ready;
      logic speed_reached;
      logic warning;
      logic battery_warning;
      logic motor_stop_warning;
      logic gain_switch;
      logic gain_switch2;
      logic abs_lost;
      logic robust_drive;
      logic closed_loop;
      logic converter_stop;
      logic brake_interlock;
      logic speed_limiting;
      logic zero_speed;
      logic torque_limiting;
   } ssof_flags_s;
endpackage

/* File: hdl/ssof_top.sv */
/*
 * Servo status output flags with an AXI4-Lite register slave.
 * Assumes the drive state comes from logic on the same CLOCK, so it is
 * not synchronised; the flags go to output drivers.
 */
`timescale 1ns/10ps

// Functional notes
// - Malfunction low when protection shuts base
// - Malfunction high after power-on window
// - In-position within range, position mode only
// - Ready high in servo-on
// - Speed reached within set plus tolerance
// - Speed reached on at set speed of 20 or below, velocity mode with servo-on
// - Warning high on warning, else window
// - Battery warning on battery warnings
// - Battery warning low with battery-less encoder
// - Stop warning on motor-stop warning
// - Gain switch flag follows gain one
// - Gain switch 2 flag follows gain two
// - Position lost flag when undetermined
// - Closed loop flag while running
// - Converter stop set by ready-on, alarm clears
// - Brake interlock off at servo-off, alarm
// - Speed limiting in torque mode only
// - Zero speed at or below level
// - Zero speed hysteresis of 20
// - Torque limiting, never in torque mode
module ssof_top #(
   parameter int PON_SINGLE = ssof_pkg::PON_SINGLE_CYC,
   parameter int PON_MULTI = ssof_pkg::PON_MULTI_CYC
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire ssof_pkg::ssof_drive_s DRIVE,
   output ssof_pkg::ssof_flags_s FLAGS,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   import ssof_pkg::*;

   // =========================================================
   // State
   // =========================================================
   // Whole module state in one struct
   typedef struct packed {
      logic [31:0] ctrl;       // Axis count and encoder type
      logic [31:0] inpos;      // In-position range in pulses
      logic [15:0] zlevel;     // Zero-speed level
      logic [31:0] brake;      // Brake delay in cycles
      logic [31:0] pon_cnt;    // Power-on counter
      logic pon_done;          // Window elapsed
      logic [31:0] brk_cnt;    // Brake release delay counter
      logic conv_run;          // Converter running latch
      logic aw_got;            // Write address held
      logic w_got;             // Write data held
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      ssof_flags_s flags;
   } ssof_state_s;

   ssof_state_s st;       // Registered state
   ssof_state_s next_st;  // Next state

   // Magnitude of a signed speed
   function automatic logic [15:0] ssof_abs(input logic [15:0] v);
      ssof_abs = v[15] ? 16'(-v) : v;
   endfunction

   // Byte-lane merge of a write into a register
   function automatic logic [31:0] ssof_merge(input logic [31:0] old,
         input logic [31:0] d, input logic [3:0] s);
      ssof_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            ssof_merge[i*8 +: 8] = d[i*8 +: 8];
         end
      end
   endfunction

   // =========================================================
   // Combinational helpers
   // =========================================================
   logic [15:0] spd_mag;    // Speed magnitude
   logic [15:0] set_mag;    // Set speed magnitude
   logic [15:0] sa_tol;     // Tolerance band half width
   logic [16:0] sa_diff; // Speed minus set speed, signed
   logic [16:0] sa_dmag; // Magnitude of that difference
   logic [31:0] pon_limit;  // Selected window count
   logic [31:0] droop_mag;  // Droop magnitude

   always_comb begin
      spd_mag = ssof_abs(DRIVE.speed);
      set_mag = ssof_abs(DRIVE.set_speed);
      // Times 0.05 done as divide by 20, so no multiplier is needed
      sa_tol = 16'(set_mag / 16'd20) + SA_OFFSET;
      // Signed difference, so a reversed motor counts as at speed only within the tolerance or at set speeds of 20 or below
      sa_diff = {DRIVE.speed[15], DRIVE.speed} -
         {DRIVE.set_speed[15], DRIVE.set_speed};
      sa_dmag = sa_diff[16] ? 17'(-sa_diff) : sa_diff;
      pon_limit = st.ctrl[CTRL_MULTI] ? 32'(PON_MULTI) : 32'(PON_SINGLE);
      droop_mag = DRIVE.droop[31] ? 32'(-DRIVE.droop) : DRIVE.droop;
   end

   // =========================================================
   // Next-state logic
   // =========================================================
   always_comb begin
      next_st = st;
      if (!st.pon_done) begin
         next_st.pon_cnt = st.pon_cnt + 32'd1;
         if (st.pon_cnt + 32'd1 >= pon_limit) begin
            next_st.pon_done = 1'b1;
         end
      end

      // --- AXI write channels, taken in either order
      if (S_AXI_AWVALID && st.awready) begin
         next_st.aw_got = 1'b1;
         next_st.awaddr = S_AXI_AWADDR;
         next_st.awready = 1'b0;
      end
      if (S_AXI_WVALID && st.wready) begin
         next_st.w_got = 1'b1;
         next_st.wdata = S_AXI_WDATA;
         next_st.wstrb = S_AXI_WSTRB;
         next_st.wready = 1'b0;
      end
      if (st.aw_got && st.w_got && !st.bvalid) begin
         // Both halves present: commit and answer
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         unique case (st.awaddr)
            REG_CTRL: next_st.ctrl = ssof_merge(st.ctrl, st.wdata, st.wstrb);
            REG_INPOS: next_st.inpos =
               ssof_merge(st.inpos, st.wdata, st.wstrb);
            REG_ZSPD: next_st.zlevel = 16'(ssof_merge({16'h0000, st.zlevel},
               st.wdata, st.wstrb));
            REG_BRAKE: next_st.brake =
               ssof_merge(st.brake, st.wdata, st.wstrb);
            REG_STATUS: next_st.bresp = RESP_OKAY; // Read-only, ignored
            default: next_st.bresp = RESP_SLVERR;
         endcase
      end
      if (st.bvalid && S_AXI_BREADY) begin
         // Response taken; reopen both channels
         next_st.bvalid = 1'b0;
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
      end

      // --- AXI read channel
      if (S_AXI_ARVALID && st.arready) begin
         next_st.arready = 1'b0;
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         unique case (S_AXI_ARADDR)
            REG_CTRL: next_st.rdata = st.ctrl;
            REG_INPOS: next_st.rdata = st.inpos;
            REG_ZSPD: next_st.rdata = {16'h0000, st.zlevel};
            REG_BRAKE: next_st.rdata = st.brake;
            REG_STATUS: next_st.rdata = {15'h0000, st.flags};
            default: begin
               next_st.rdata = 32'h0000_0000;
               next_st.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (st.rvalid && S_AXI_RREADY) begin
         next_st.rvalid = 1'b0;
         next_st.arready = 1'b1;
      end

      // --- Status flags
      // malfunction: off on trip, on once window passes
      next_st.flags.malfunction = st.pon_done && !DRIVE.base_shutoff &&
         !DRIVE.alarm;
      next_st.flags.in_position = (DRIVE.mode == SSOF_POS) &&
         (droop_mag <= st.inpos);
      next_st.flags.ready = DRIVE.servo_on;
      // speed reached, velocity mode, off at servo-off
      next_st.flags.speed_reached = DRIVE.servo_on &&
         (DRIVE.mode == SSOF_VEL) && ((set_mag <= SA_MIN_SET) ||
         (sa_dmag <= {1'b0, sa_tol}));
      // warning: on during power-on window, then follows warnings
      next_st.flags.warning = DRIVE.warning || !st.pon_done;
      // battery warning, forced low when battery-less
      next_st.flags.battery_warning = !st.ctrl[CTRL_BATLESS] &&
         (DRIVE.bat_warning || !st.pon_done);
      next_st.flags.motor_stop_warning = DRIVE.stop_warning ||
         !st.pon_done;
      next_st.flags.gain_switch = DRIVE.gain1;
      next_st.flags.gain_switch2 = DRIVE.gain2;
      next_st.flags.abs_lost = DRIVE.abs_lost;
      // Robust drive flag is never driven on
      next_st.flags.robust_drive = 1'b0;
      next_st.flags.closed_loop = DRIVE.closed_loop;
      // converter stop: set by ready-on, alarm wins
      if (DRIVE.conv_alarm) begin
         next_st.conv_run = 1'b0;
      end else if (DRIVE.ready_on_cmd) begin
         next_st.conv_run = 1'b1;
      end
      next_st.flags.converter_stop = next_st.conv_run;
      // brake interlock released after delay, dropped at once
      if (!DRIVE.servo_on || DRIVE.alarm) begin
         next_st.brk_cnt = 32'd0;
         next_st.flags.brake_interlock = 1'b0;
      end else if (st.brk_cnt < st.brake) begin
         next_st.brk_cnt = st.brk_cnt + 32'd1;
      end else begin
         next_st.flags.brake_interlock = 1'b1;
      end
      // speed limiting in torque mode while servo-on
      next_st.flags.speed_limiting = DRIVE.servo_on &&
         (DRIVE.mode == SSOF_TRQ) && DRIVE.at_speed_limit;
      if (spd_mag <= st.zlevel) begin
         next_st.flags.zero_speed = 1'b1;
      end else if ({1'b0, spd_mag} >= {1'b0, st.zlevel} + {1'b0, ZSP_HYST})
      begin
         next_st.flags.zero_speed = 1'b0;
      end
      // torque limiting, off at servo-off and in torque mode
      next_st.flags.torque_limiting = DRIVE.servo_on &&
         (DRIVE.mode != SSOF_TRQ) && DRIVE.at_torque_limit;

      // Synchronous reset
      if (!RSTN) begin
         next_st = '0;
         next_st.ctrl = CTRL_RST;
         next_st.inpos = INPOS_RST;
         next_st.zlevel = ZSP_LEVEL_RST;
         next_st.brake = BRAKE_RST;
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
         next_st.arready = 1'b1;
         // Warnings read high until the window ends
         next_st.flags.warning = 1'b1;
         next_st.flags.motor_stop_warning = 1'b1;
         next_st.flags.battery_warning = 1'b1;
      end
   end

   // =========================================================
   // State register
   // =========================================================
   always_ff @(posedge CLOCK) begin
      st <= next_st;
   end

   // Outputs straight from flip-flops
   assign FLAGS = st.flags;
   assign S_AXI_AWREADY = st.awready;
   assign S_AXI_WREADY = st.wready;
   assign S_AXI_BVALID = st.bvalid;
   assign S_AXI_BRESP = st.bresp;
   assign S_AXI_ARREADY = st.arready;
   assign S_AXI_RVALID = st.rvalid;
   assign S_AXI_RDATA = st.rdata;
   assign S_AXI_RRESP = st.rresp;

   // =========================================================
   // Assertions
   // =========================================================
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   a_malf_trip_off: assert property (
      DRIVE.base_shutoff |=> !FLAGS.malfunction)
      else $error("malfunction high after trip");
   a_malf_early_off: assert property (
      !st.pon_done |=> !FLAGS.malfunction)
      else $error("malfunction high inside window");
   a_inpos_mode: assert property (
      DRIVE.mode != SSOF_POS |=> !FLAGS.in_position)
      else $error("in-position outside position mode");
   a_ready_follow: assert property (
      DRIVE.servo_on |=> FLAGS.ready)
      else $error("ready missing at servo-on");
   a_sa_servo_off: assert property (
      !DRIVE.servo_on |=> !FLAGS.speed_reached)
      else $error("speed reached at servo-off");
   a_batless_low: assert property (
      st.ctrl[CTRL_BATLESS] |=> !FLAGS.battery_warning)
      else $error("battery warning with battery-less encoder");
   a_warn_active: assert property (
      DRIVE.warning |=> FLAGS.warning)
      else $error("warning not shown");
   a_conv_alarm: assert property (
      DRIVE.conv_alarm |=> !FLAGS.converter_stop)
      else $error("converter stop held over alarm");
   a_brake_off: assert property (
      (!DRIVE.servo_on || DRIVE.alarm) |=> !FLAGS.brake_interlock)
      else $error("brake interlock on at servo-off or alarm");
   a_zsp_hyst: assert property (
      FLAGS.zero_speed && spd_mag < st.zlevel + ZSP_HYST &&
      $stable(st.zlevel) |=> FLAGS.zero_speed)
      else $error("zero speed cleared inside hysteresis");
   a_tlc_trq: assert property (
      DRIVE.mode == SSOF_TRQ |=> !FLAGS.torque_limiting)
      else $error("torque limiting in torque mode");

   // Set-speed floor, mode limits and warnings that must show
   a_sa_low_set: assert property (
      DRIVE.servo_on && DRIVE.mode == SSOF_VEL && set_mag <= SA_MIN_SET
      |=> FLAGS.speed_reached)
      else $error("speed reached off at low set speed");
   a_sa_mode: assert property (
      DRIVE.mode != SSOF_VEL |=> !FLAGS.speed_reached)
      else $error("speed reached outside velocity mode");
   a_vlc_mode: assert property (
      DRIVE.mode != SSOF_TRQ |=> !FLAGS.speed_limiting)
      else $error("speed limiting outside torque mode");
   a_bwarn_on: assert property (
      !st.ctrl[CTRL_BATLESS] && DRIVE.bat_warning |=> FLAGS.battery_warning)
      else $error("battery warning not shown");
   a_stop_warn: assert property (
      DRIVE.stop_warning |=> FLAGS.motor_stop_warning)
      else $error("motor stop warning not shown");
   // Plain followers and zero-speed set: a stuck flag would hide a drive fault
   a_gain_one: assert property (
      DRIVE.gain1 |=> FLAGS.gain_switch)
      else $error("gain switch flag missing");
   a_gain_two: assert property (
      DRIVE.gain2 |=> FLAGS.gain_switch2)
      else $error("gain switch 2 flag missing");
   a_abs_lost: assert property (
      DRIVE.abs_lost |=> FLAGS.abs_lost)
      else $error("position lost flag missing");
   a_cl_active: assert property (
      DRIVE.closed_loop |=> FLAGS.closed_loop)
      else $error("closed loop flag missing");
   a_zsp_on: assert property (
      spd_mag <= st.zlevel |=> FLAGS.zero_speed)
      else $error("zero speed missing at low speed");
endmodule // ssof_top

/* File: verification/ssof_ctrl_model.sv */
/*
 * Machine controller model: latches the status flags into its input
 * image on every clock, as a discrete input card would.
 * Assumes it shares CLOCK and RSTN with the flag block.
 */
`timescale 1ns/10ps
module ssof_ctrl_model (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire ssof_pkg::ssof_flags_s FLAGS,
   output ssof_pkg::ssof_flags_s SEEN
);
   import ssof_pkg::*;
   // ======================================================
   // Input image
   // ======================================================
   // One cycle of capture latency; the bench waits long enough for it
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         // Unpowered card reads all inputs off
         SEEN <= '0;
      end else begin
         SEEN <= FLAGS;
      end
   end
endmodule // ssof_ctrl_model

/* File: verification/tb_servo_status_output_flags.sv */
/*
 * Self-checking bench for the status flag block: AXI4-Lite register
 * access, drive state stimulus and flag comparisons.
 * Assumes ssof_pkg is compiled first; power-on windows are shortened.
 */
`timescale 1ns/10ps
module tb_servo_status_output_flags;
   import ssof_pkg::*;
   // ======================================================
   // Signals
   // ======================================================
   localparam int PS = 20; // Short single-axis window, cycles
   localparam int PM = 60; // Short multi-axis window, cycles
   logic CLOCK = 1'b0;
   logic RSTN = 1'b0;
   ssof_drive_s drv = '0; // Drive state applied to the block
   ssof_drive_s d = '0; // Working copy edited by the tests
   ssof_flags_s flags;
   ssof_flags_s seen; // Controller's view of the flags
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   int err_total = 0;
   int checks_done = 0;
   // Speed sweep for the zero-speed flag and the flag expected after it
   logic [15:0] zs [8] = '{16'h0000, 16'h0045, 16'h0046, 16'h0045,
      16'h0032, 16'hFFBB, 16'hFFBA, 16'hFFCE};
   logic zz [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

   // ======================================================
   // Block and controller model
   // ======================================================
   ssof_top #(.PON_SINGLE(PS), .PON_MULTI(PM)) u_dut (
      .CLOCK(CLOCK), .RSTN(RSTN), .DRIVE(drv), .FLAGS(flags),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready)
   );
   ssof_ctrl_model u_ctrl (
      .CLOCK(CLOCK), .RSTN(RSTN), .FLAGS(flags), .SEEN(seen)
   );

   // ======================================================
   // Clock and tasks
   // ======================================================
   // 10 MHz system clock
   initial begin
      forever #50 CLOCK = ~CLOCK;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
   endtask
   // Apply the working copy and let it reach the controller image
   task automatic put();
      drv <= d;
      cyc(3);
   endtask
   task automatic chkf(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkr(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Write: address and data offered together, each dropped when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] v,
                      output logic [1:0] r);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge CLOCK);
         if (awvalid && awready) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge CLOCK); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      // One idle edge so the next call never reassigns in this step
      @(posedge CLOCK);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge CLOCK); while (!(arvalid && arready));
      arvalid <= 1'b0;
      do @(posedge CLOCK); while (!rvalid);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge CLOCK);
   endtask
   task automatic finish_test();
      $display("Checks %0d, errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Watchdog far beyond the expected run of about three hundred cycles
   initial begin
      cyc(20000);
      err_total++;
      finish_test();
   end

   // ======================================================
   // Tests
   // ======================================================
   initial begin
      cyc(20);
      RSTN <= 1'b1;
      // Inside the window warnings are forced on, malfunction is off
      cyc(10);
      chkf(seen.malfunction, 1'b0);
      chkf(seen.warning, 1'b1);
      chkf(seen.battery_warning, 1'b1);
      chkf(seen.motor_stop_warning, 1'b1);
      cyc(30);
      chkf(seen.malfunction, 1'b1);
      chkf(seen.warning, 1'b0);
      chkf(seen.battery_warning, 1'b0);
      chkf(seen.motor_stop_warning, 1'b0);
      // Idle drive: malfunction, in-position and zero speed only
      axr(REG_STATUS, rd, rsp);
      chkr(rd, 32'h0001_8002);
      // Reset values, unmapped place and read-only status
      axr(REG_CTRL, rd, rsp);
      chkr(rd, CTRL_RST);
      axr(REG_INPOS, rd, rsp);
      chkr(rd, INPOS_RST);
      axr(REG_ZSPD, rd, rsp);
      chkr(rd, 32'h0000_0032);
      axr(REG_BRAKE, rd, rsp);
      chkr(rd, BRAKE_RST);
      axr(8'h14, rd, rsp);
      chkr(rd, 32'h0000_0000);
      chkr({30'h0, rsp}, {30'h0, RESP_SLVERR});
      axw(8'h14, 32'h1, rsp);
      chkr({30'h0, rsp}, {30'h0, RESP_SLVERR});
      axw(REG_STATUS, 32'hFFFF_FFFF, rsp);
      chkr({30'h0, rsp}, {30'h0, RESP_OKAY});
      // Status must be unchanged by the ignored write
      axr(REG_STATUS, rd, rsp);
      chkr(rd, 32'h0001_8002);
      // Plain followers and the always-off flag
      d.gain1 = 1'b1;
      d.gain2 = 1'b1;
      d.abs_lost = 1'b1;
      d.closed_loop = 1'b1;
      d.servo_on = 1'b1;
      put();
      chkf(seen.gain_switch, 1'b1);
      chkf(seen.gain_switch2, 1'b1);
      chkf(seen.abs_lost, 1'b1);
      chkf(seen.closed_loop, 1'b1);
      chkf(seen.ready, 1'b1);
      chkf(seen.robust_drive, 1'b0);
      d = '0;
      put();
      chkf(seen.gain_switch | seen.gain_switch2, 1'b0);
      chkf(seen.abs_lost | seen.closed_loop, 1'b0);
      chkf(seen.ready, 1'b0);
      // In-position edge of the default range, then velocity mode
      d.droop = 32'd101;
      put();
      chkf(seen.in_position, 1'b0);
      d.droop = 32'hFFFF_FF9C;
      put();
      chkf(seen.in_position, 1'b1);
      d.mode = SSOF_VEL;
      put();
      chkf(seen.in_position, 1'b0);
      // Speed reached, set 1000: tolerance 70
      d.servo_on = 1'b1;
      d.set_speed = 16'h03E8;
      d.speed = 16'h042E;
      put();
      chkf(seen.speed_reached, 1'b1);
      d.speed = 16'h03A1;
      put();
      chkf(seen.speed_reached, 1'b0);
      // Reverse rotation at the same magnitude is not at speed
      d.speed = 16'hFC18;
      put();
      chkf(seen.speed_reached, 1'b0);
      d.set_speed = 16'hFC18;
      put();
      chkf(seen.speed_reached, 1'b1);
      d.set_speed = 16'h0014;
      put();
      chkf(seen.speed_reached, 1'b1);
      d.servo_on = 1'b0;
      put();
      chkf(seen.speed_reached, 1'b0);
      d.servo_on = 1'b1;
      d.mode = SSOF_POS;
      put();
      chkf(seen.speed_reached, 1'b0);
      // Zero speed with hysteresis, both directions
      for (int i = 0; i < 8; i++) begin
         d.speed = zs[i];
         put();
         chkf(seen.zero_speed, zz[i]);
      end
      axw(REG_ZSPD, 32'h0000_0064, rsp);
      d.speed = 16'h0078;
      put();
      chkf(seen.zero_speed, 1'b0);
      d.speed = 16'h0064;
      put();
      chkf(seen.zero_speed, 1'b1);
      // Torque and speed limiting by mode and servo state
      d.at_torque_limit = 1'b1;
      d.at_speed_limit = 1'b1;
      put();
      chkf(seen.torque_limiting, 1'b1);
      chkf(seen.speed_limiting, 1'b0);
      d.mode = SSOF_TRQ;
      put();
      chkf(seen.torque_limiting, 1'b0);
      chkf(seen.speed_limiting, 1'b1);
      d.servo_on = 1'b0;
      put();
      chkf(seen.speed_limiting, 1'b0);
      d.mode = SSOF_POS;
      put();
      chkf(seen.torque_limiting, 1'b0);
      // Brake delay of five cycles, dropped at once by an alarm
      axw(REG_BRAKE, 32'h0000_0005, rsp);
      d.servo_on = 1'b1;
      drv <= d;
      cyc(3);
      chkf(seen.brake_interlock, 1'b0);
      cyc(6);
      chkf(seen.brake_interlock, 1'b1);
      d.alarm = 1'b1;
      put();
      chkf(seen.brake_interlock, 1'b0);
      chkf(seen.malfunction, 1'b0);
      d.alarm = 1'b0;
      d.base_shutoff = 1'b1;
      put();
      chkf(seen.malfunction, 1'b0);
      d.base_shutoff = 1'b0;
      // Converter latch: set by ready-on, cleared by alarm, alarm wins
      d.ready_on_cmd = 1'b1;
      put();
      d.ready_on_cmd = 1'b0;
      put();
      chkf(seen.converter_stop, 1'b1);
      d.ready_on_cmd = 1'b1;
      d.conv_alarm = 1'b1;
      put();
      chkf(seen.converter_stop, 1'b0);
      d = '0;
      // Warnings follow their inputs after the window
      d.warning = 1'b1;
      d.bat_warning = 1'b1;
      d.stop_warning = 1'b1;
      put();
      chkf(seen.warning, 1'b1);
      chkf(seen.battery_warning, 1'b1);
      chkf(seen.motor_stop_warning, 1'b1);
      // Second reset, multi-axis window chosen at once
      RSTN <= 1'b0;
      cyc(2);
      RSTN <= 1'b1;
      d = '0;
      drv <= d;
      axw(REG_CTRL, 32'h0000_0001, rsp);
      cyc(35);
      chkf(seen.malfunction, 1'b0);
      cyc(40);
      chkf(seen.malfunction, 1'b1);
      // Battery-less encoder hides battery warnings
      axw(REG_CTRL, 32'h0000_0002, rsp);
      d.bat_warning = 1'b1;
      put();
      chkf(seen.battery_warning, 1'b0);
      finish_test();
   end
endmodule // tb_servo_status_output_flags
